// *** hdl/ock_pkg.sv ***
package ock_pkg;
    // ************************************************************
    // Timing counts and reset values.
    // ************************************************************
    localparam int OCK_STARTUP_CYCLES = 128;
    localparam int OCK_SLEEP_CYCLES = 16;
    localparam logic [1:0] OCK_RATIO_1 = 2'h0;
    localparam logic [1:0] OCK_RATIO_8 = 2'h3;
    localparam logic [1:0] OCK_RATIO_RESET = OCK_RATIO_8;
    localparam logic OCK_ENABLE_RESET = 1'h1;

    // Power states of the device clocking.
    typedef enum logic [1:0] {
        OCK_ST_STARTUP = 2'b00,
        OCK_ST_RUN = 2'b01,
        OCK_ST_DRAIN = 2'b10,
        OCK_ST_SLEEP = 2'b11
    } ock_state_t;

    // Half period of the output in input clocks for a ratio code; ratio 1 is handled apart.
    function automatic logic [2:0] ock_half(input logic [1:0] code);
        ock_half = 3'h1 << (code - 2'h1);
    endfunction
endpackage

// *** hdl/ock_div_if.sv ***
`timescale 1ns/10ps
// Carries the divider controls and its period strobe between control and divider.
interface ock_div_if;
    logic run;
    logic [1:0] ratio;
    logic period_end;
    logic level;
    modport ctrl (output run, output ratio, input period_end, input level);
    modport div (input run, input ratio, output period_end, output level);
endinterface

// *** hdl/ock_divider.sv ***
`timescale 1ns/10ps
// Prescaler that emits whole output periods only.
module ock_divider
    import ock_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    ock_div_if.div dv
);
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic lvl;
    logic next_lvl;
    logic [1:0] cur;
    logic [1:0] next_cur;
    logic period_end;

    // ************************************************************
    // Counter and phase.
    // ************************************************************

    // The ratio is latched only at a period end or while stopped, so no phase is ever cut short.
    always_comb begin
        next_cnt = cnt;
        next_lvl = lvl;
        next_cur = cur;
        period_end = 1'b0;
        if (!dv.run) begin
            next_cnt = 3'h0;
            next_lvl = 1'b0;
            next_cur = dv.ratio;
        end else if (cur == OCK_RATIO_1) begin
            next_lvl = ~lvl;
            period_end = lvl; // A falling step ends a period.
            if (lvl) begin
                next_cur = dv.ratio;
            end
        end else if (cnt + 3'h1 >= ock_half(cur)) begin
            next_cnt = 3'h0;
            next_lvl = ~lvl;
            period_end = lvl;
            if (lvl) begin
                next_cur = dv.ratio;
            end
        end else begin
            next_cnt = cnt + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'h0;
            lvl <= 1'b0;
            cur <= OCK_RATIO_RESET;
        end else begin
            cnt <= next_cnt;
            lvl <= next_lvl;
            cur <= next_cur;
        end
    end

    assign dv.period_end = period_end;
    assign dv.level = lvl;
endmodule

// *** hdl/ock_clock_ctrl.sv ***
`timescale 1ns/10ps
// Start-up timer and clock output control.
module ock_clock_ctrl
    import ock_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clock_out_enable,
    input wire logic [1:0] ratio_sel,
    input wire logic sleep_req,
    input wire logic wake_req,
    output logic internal_reset_n,
    output logic oscillator_run,
    output logic asleep,
    output logic clock_out_pin_o,
    output logic clock_out_pin_oe
);
    ock_div_if dv();
    ock_state_t state;
    ock_state_t next_state;
    logic [7:0] oscillator_startup_timer;
    logic [7:0] next_ost;
    logic [4:0] drain;
    logic [4:0] next_drain;
    logic en_act;
    logic next_en_act;
    logic [1:0] ratio_reg;
    logic [1:0] next_ratio_reg;
    logic next_internal_reset_n;
    logic next_oscillator_run;
    logic next_asleep;
    logic next_pin_o;
    logic next_pin_oe;
    logic [7:0] tmo;
    logic drain_seen;
    logic pe_d;
    logic next_pe_d;
    logic [1:0] per_ratio;

    ock_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .dv(dv)
    );

    // ************************************************************
    // Power state machine.
    // ************************************************************

    // Start-up counts, run waits for sleep, drain counts output periods.
    always_comb begin
        next_state = state;
        next_ost = oscillator_startup_timer;
        next_drain = drain;
        case (state)
            OCK_ST_STARTUP: begin
                if (oscillator_startup_timer == 8'(OCK_STARTUP_CYCLES - 1)) begin
                    next_state = OCK_ST_RUN;
                end else begin
                    next_ost = oscillator_startup_timer + 8'h1;
                end
            end
            OCK_ST_RUN: begin
                if (sleep_req) begin
                    next_state = OCK_ST_DRAIN;
                    next_drain = 5'h0;
                end
            end
            OCK_ST_DRAIN: begin
                if (dv.period_end) begin
                    next_drain = drain + 5'h1;
                    if (drain == 5'(OCK_SLEEP_CYCLES - 1)) begin
                        next_state = OCK_ST_SLEEP;
                    end
                end
            end
            OCK_ST_SLEEP: begin
                if (wake_req) begin
                    next_state = OCK_ST_STARTUP;
                    next_ost = 8'h0;
                end
            end
            default: begin
                next_state = OCK_ST_STARTUP;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= OCK_ST_STARTUP;
            oscillator_startup_timer <= 8'h0;
            drain <= 5'h0;
        end else begin
            state <= next_state;
            oscillator_startup_timer <= next_ost;
            drain <= next_drain;
        end
    end

    // ************************************************************
    // Output control, applied at period boundaries.
    // ************************************************************

    // The pin lags the divider by one cycle, so an enable change waits for the cycle after a period end.
    // Taking it at any low cycle would cut the first low phase after enabling short.
    always_comb begin
        next_en_act = en_act;
        next_ratio_reg = ratio_sel;
        next_pe_d = dv.period_end;
        if (pe_d || !dv.run) begin
            next_en_act = clock_out_enable;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_act <= OCK_ENABLE_RESET;
            ratio_reg <= OCK_RATIO_RESET;
            pe_d <= 1'b0;
        end else begin
            en_act <= next_en_act;
            ratio_reg <= next_ratio_reg;
            pe_d <= next_pe_d;
        end
    end

    assign dv.run = (state != OCK_ST_SLEEP);
    assign dv.ratio = ratio_reg;

    // Pins and status come straight from flip-flops.
    always_comb begin
        next_internal_reset_n = (next_state != OCK_ST_STARTUP);
        next_oscillator_run = (next_state != OCK_ST_SLEEP);
        next_asleep = (next_state == OCK_ST_SLEEP);
        next_pin_oe = next_en_act;
        next_pin_o = next_en_act && (state != OCK_ST_SLEEP) && dv.level;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            internal_reset_n <= 1'b0;
            oscillator_run <= 1'b1;
            asleep <= 1'b0;
            clock_out_pin_o <= 1'b0;
            clock_out_pin_oe <= 1'b1;
        end else begin
            internal_reset_n <= next_internal_reset_n;
            oscillator_run <= next_oscillator_run;
            asleep <= next_asleep;
            clock_out_pin_o <= next_pin_o;
            clock_out_pin_oe <= next_pin_oe;
        end
    end

    // ************************************************************
    // Checks.
    // ************************************************************

    // Helper: cycles spent in start-up since its entry.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tmo <= 8'h0;
        end else if (state == OCK_ST_STARTUP) begin
            tmo <= tmo + 8'h1;
        end else begin
            tmo <= 8'h0;
        end
    end
    // Helper: the ratio that the current output period is counted with.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            per_ratio <= OCK_RATIO_RESET;
        end else if (dv.period_end || !dv.run) begin
            per_ratio <= ratio_reg;
        end
    end
    assign drain_seen = (state == OCK_ST_DRAIN);

    property p_startup_len;
        @(posedge clk) disable iff (!rst_n) (state == OCK_ST_RUN && $past(state) == OCK_ST_STARTUP)
            |-> $past(tmo) == 8'(OCK_STARTUP_CYCLES - 1);
    endproperty
    a_startup_len: assert property (p_startup_len) else $error("Start-up did not last 128 cycles.");

    property p_reset_held;
        @(posedge clk) disable iff (!rst_n) $rose(internal_reset_n) |-> $past(state) == OCK_ST_STARTUP;
    endproperty
    a_reset_held: assert property (p_reset_held) else $error("Internal reset released outside start-up.");

    property p_sleep_low;
        @(posedge clk) disable iff (!rst_n) (state == OCK_ST_SLEEP) ##1 (state == OCK_ST_SLEEP) |-> !clock_out_pin_o;
    endproperty
    a_sleep_low: assert property (p_sleep_low) else $error("Clock output high in sleep.");

    property p_drain_count;
        @(posedge clk) disable iff (!rst_n) (state == OCK_ST_DRAIN && next_state == OCK_ST_SLEEP)
            |-> drain == 5'(OCK_SLEEP_CYCLES - 1);
    endproperty
    a_drain_count: assert property (p_drain_count) else $error("Sleep entered without sixteen cycles.");

    property p_wake_restart;
        @(posedge clk) disable iff (!rst_n) (state == OCK_ST_SLEEP && wake_req) |=> state == OCK_ST_STARTUP && oscillator_startup_timer == 8'h0;
    endproperty
    a_wake_restart: assert property (p_wake_restart) else $error("Wake did not restart the timer.");

    property p_hiz_off;
        @(posedge clk) disable iff (!rst_n) !clock_out_pin_oe |-> !clock_out_pin_o;
    endproperty
    a_hiz_off: assert property (p_hiz_off) else $error("Pin driven high while released.");

    property p_no_runt_high;
        @(posedge clk) disable iff (!rst_n) $rose(clock_out_pin_o) && per_ratio == OCK_RATIO_8 |-> clock_out_pin_o [*4];
    endproperty
    a_no_runt_high: assert property (p_no_runt_high) else $error("High phase cut short.");

    // A release must follow the last high cycle of a period, or happen while asleep.
    property p_disable_at_low;
        @(posedge clk) disable iff (!rst_n) $fell(clock_out_pin_oe)
            |-> $past(clock_out_pin_o) || $past(state) == OCK_ST_SLEEP;
    endproperty
    a_disable_at_low: assert property (p_disable_at_low) else $error("Clock output released before its period ended.");

    c_startup_done: cover property (@(posedge clk) disable iff (!rst_n) $rose(internal_reset_n));
    c_sleep: cover property (@(posedge clk) disable iff (!rst_n) $rose(asleep));
    c_wake: cover property (@(posedge clk) disable iff (!rst_n) drain_seen ##[1:400] (state == OCK_ST_STARTUP));
    c_disable: cover property (@(posedge clk) disable iff (!rst_n) $fell(clock_out_pin_oe));
endmodule

// *** testbench/ock_host_model.sv ***
`timescale 1ns/10ps
// ************************************************************
// Host that samples the clock output pin on the oscillator clock.
// ************************************************************
module ock_host_model (
    input wire logic clk,
    input wire logic clr,
    input wire logic pin,
    output logic [15:0] falls,
    output logic [7:0] min_phase
);
    logic last;
    logic [7:0] run;
    // Times each phase that ends with a change between two driven levels and counts falling edges.
    always @(posedge clk) begin
        if (clr) begin
            falls <= 16'h0;
            min_phase <= 8'hff;
        end else if (pin !== last) begin
            if ((pin === 1'b0 || pin === 1'b1) && (last === 1'b0 || last === 1'b1) && run < min_phase) begin
                min_phase <= run;
            end
            if (last === 1'b1 && pin === 1'b0) begin
                falls <= falls + 16'h1;
            end
        end
        run <= (pin === last) ? run + 8'h1 : 8'h1;
        last <= pin;
    end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    import ock_pkg::*;
    logic clk, rst_n, clock_out_enable, sleep_req, wake_req, host_clr;
    logic [1:0] ratio_sel;
    logic internal_reset_n, oscillator_run, asleep, clock_out_pin_o, clock_out_pin_oe;
    logic [15:0] host_falls, p;
    logic [7:0] host_min, lfsr;
    int num_errors, n_compared, k;
    // The pin floats whenever the device releases it.
    wire pin = clock_out_pin_oe ? clock_out_pin_o : 1'bz;

    ock_clock_ctrl dut (.clk(clk), .rst_n(rst_n), .clock_out_enable(clock_out_enable), .ratio_sel(ratio_sel),
        .sleep_req(sleep_req), .wake_req(wake_req), .internal_reset_n(internal_reset_n),
        .oscillator_run(oscillator_run), .asleep(asleep), .clock_out_pin_o(clock_out_pin_o),
        .clock_out_pin_oe(clock_out_pin_oe));
    ock_host_model host (.clk(clk), .clr(host_clr), .pin(pin), .falls(host_falls), .min_phase(host_min));

    // ************************************************************
    // Helpers.
    // ************************************************************
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    function automatic logic [15:0] exp_period(input logic [1:0] c);
        return (c == 2'h0) ? 16'h2 : (16'h1 << c);
    endfunction
    function automatic logic pick(input int w);
        return (w == 0) ? clock_out_pin_oe : (w == 1) ? asleep : internal_reset_n;
    endfunction
    task automatic edges(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic hold_for(input int w, input logic v, output int n);
        n = 0;
        while (pick(w) !== v && n < 400) begin
            edges(1);
            n++;
        end
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    // Measures one full output period from rising edge to rising edge.
    task automatic meas();
        logic prev;
        int n, seen;
        prev = clock_out_pin_o;
        n = 0;
        seen = 0;
        p = 16'h0;
        for (int i = 0; i < 60 && seen < 2; i++) begin
            edges(1);
            n++;
            if (prev === 1'b0 && clock_out_pin_o === 1'b1) begin
                seen++;
                p = 16'(n);
                n = 0;
            end
            prev = clock_out_pin_o;
        end
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Oscillator clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Watchdog against a hang.
    initial begin
        #100000;
        num_errors++;
        report_and_stop();
    end

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        rst_n = 1'b0;
        clock_out_enable = 1'b1;
        ratio_sel = 2'h3;
        sleep_req = 1'b0;
        wake_req = 1'b0;
        host_clr = 1'b1;
        lfsr = 8'h34;
        num_errors = 0;
        n_compared = 0;
        edges(20);
        check(clock_out_pin_oe, 1'b1, "oe in reset");
        @(posedge clk);
        rst_n <= 1'b1;
        #1;
        hold_for(2, 1'b1, k);
        check(16'(k), 16'(OCK_STARTUP_CYCLES), "startup");
        meas();
        check(p, 16'h8, "reset period");
        for (int i = 0; i < 7; i++) begin
            lfsr = nxt(lfsr);
            @(posedge clk);
            ratio_sel <= (i < 4) ? 2'(i) : lfsr[1:0];
            meas();
            meas();
            check(p, exp_period(ratio_sel), "period");
        end
        // Settle at the slowest ratio before the host starts timing phases.
        @(posedge clk);
        ratio_sel <= 2'h3;
        edges(20);
        host_clr <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            lfsr = nxt(lfsr);
            @(posedge clk);
            ratio_sel <= {1'b1, lfsr[0]};
            clock_out_enable <= lfsr[1] | lfsr[2];
            edges(int'(lfsr[7:4]) + 1);
        end
        @(posedge clk);
        clock_out_enable <= 1'b0;
        #1;
        hold_for(0, 1'b0, k);
        edges(8);
        check(clock_out_pin_oe, 1'b0, "disable");
        check(host_min >= 8'h2, 1'b1, "min phase");
        @(posedge clk);
        clock_out_enable <= 1'b1;
        ratio_sel <= 2'(nxt(lfsr));
        #1;
        hold_for(0, 1'b1, k);
        check(clock_out_pin_oe, 1'b1, "enable");
        meas();
        meas();
        check(p, exp_period(ratio_sel), "period after enable");
        @(posedge clk);
        sleep_req <= 1'b1;
        host_clr <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        // Falls from periods that ended before the request was taken are not counted.
        repeat (2) @(posedge clk);
        host_clr <= 1'b0;
        #1;
        hold_for(1, 1'b1, k);
        edges(2);
        check(host_falls, 16'(OCK_SLEEP_CYCLES), "sleep cycles");
        edges(30);
        check(clock_out_pin_o, 1'b0, "sleep level");
        check(host_falls, 16'(OCK_SLEEP_CYCLES), "quiet in sleep");
        check(oscillator_run, 1'b0, "osc stopped");
        @(posedge clk);
        wake_req <= 1'b1;
        @(posedge clk);
        wake_req <= 1'b0;
        #1;
        hold_for(2, 1'b0, k);
        hold_for(2, 1'b1, k);
        check(16'(k), 16'(OCK_STARTUP_CYCLES), "wake startup");
        check({asleep, oscillator_run}, 2'b01, "awake");
        report_and_stop();
    end
endmodule
